//--- inc/swout_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the switch
 * output controller. Assumes a 100 MHz clock and a 32-bit Wishbone bus.
 */
`ifndef SWOUT_CFG_SVH
`define SWOUT_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define SWOUT_CTRL_ADDR 8'h00
`define SWOUT_ON_THR_ADDR 8'h04
`define SWOUT_OFF_THR_ADDR 8'h08
`define SWOUT_ON_DLY_ADDR 8'h0c
`define SWOUT_OFF_DLY_ADDR 8'h10
`define SWOUT_STATUS_ADDR 8'h14

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define SWOUT_FUNC_LSB 0
`define SWOUT_DIAG_LSB 4
`define SWOUT_DSRC_LSB 8
`define SWOUT_LSEL_LSB 12
`define SWOUT_FAIL_LSB 16
`define SWOUT_INV_BIT 20

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
// Failure state resets to open; limit variable 1 so the delays apply
`define SWOUT_CTRL_RST 32'h0001_1000
`define SWOUT_THR_RST 32'h0000_0000
`define SWOUT_DLY_RST 16'h0000

// ----------------------------------------------------------------------------
// Timing: delays count in 0.1 s ticks, max 100.0 s
// ----------------------------------------------------------------------------
`define SWOUT_CLK_HZ 100000000
`define SWOUT_TICK_MS 100
`define SWOUT_TICK_CYCLES (`SWOUT_CLK_HZ / 1000 * `SWOUT_TICK_MS)
`define SWOUT_DLY_MAX 16'h03e8

`endif

//--- inc/swout_pkg.sv
/*
 * Types of the switch output controller.
 * Assumes swout_cfg.svh holds the numeric constants.
 */
package swout_pkg;

    typedef enum logic [2:0] {
        FUNC_OFF, FUNC_ON, FUNC_DIAG, FUNC_LIMIT, FUNC_DOUT
    } func_t;

    typedef enum logic [1:0] {
        DIAG_ALARM, DIAG_ALARM_WARN, DIAG_WARN
    } diag_class_t;

    typedef enum logic [1:0] {
        FAIL_ACTUAL, FAIL_OPEN, FAIL_CLOSED
    } fail_mode_t;

endpackage

//--- logic/swout_tick.sv
/*
 * Fixed time base: one-cycle pulse every PERIOD clocks.
 * Assumes a single synchronous clock domain.
 */
`timescale 1ns/100ps
`include "swout_cfg.svh"

module swout_tick #(
    parameter int PERIOD = `SWOUT_TICK_CYCLES
) (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Synchronous reset
    output logic tick_o // Tick pulse
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } tick_state_t;

    tick_state_t s;
    tick_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (s.cnt >= 32'(PERIOD - 1)) begin
            next_s.cnt = 32'h0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick_o = s.tick;
endmodule // swout_tick

//--- logic/swout_delay.sv
/*
 * Delayed follower: output takes the target level after it has been
 * stable for the configured number of ticks. Assumes a one-cycle tick.
 */
`timescale 1ns/100ps

module swout_delay #(
    parameter int DW = 16
) (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Synchronous reset
    input wire logic tick_i, // Time base pulse
    input wire logic target_i, // Wanted level
    input wire logic [DW-1:0] on_dly_i, // Ticks before closing
    input wire logic [DW-1:0] off_dly_i, // Ticks before opening
    output logic level_o // Delayed level
);
    typedef struct packed {
        logic [DW-1:0] cnt;
        logic level;
    } dly_state_t;

    dly_state_t s;
    dly_state_t next_s;
    logic [DW-1:0] limit;

    always_comb begin
        next_s = s;
        limit = target_i ? on_dly_i : off_dly_i;
        if (target_i == s.level) begin
            next_s.cnt = '0;
        end else if (s.cnt >= limit) begin
            next_s.level = target_i;
            next_s.cnt = '0;
        end else if (tick_i) begin
            next_s.cnt = s.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level_o = s.level;
endmodule // swout_delay

//--- logic/swout_ctrl.sv
/*
 * Switch output controller: function selection, limit comparator with
 * hysteresis and delays, failure override, inversion, Wishbone registers.
 * Assumes measured values and event inputs are on clk_i already.
 */
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/100ps
`include "swout_cfg.svh"

module swout_ctrl
    import swout_pkg::*;
#(
    parameter int TICK_CYCLES = `SWOUT_TICK_CYCLES,
    parameter int NUM_VARS = 6,
    parameter int NUM_DO = 8
) (
    input wire logic clk_i, // Clock, 100 MHz
    input wire logic rst_i, // Synchronous reset
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic [NUM_VARS*32-1:0] meas_i, // Signed measured variables
    input wire logic alarm_i, // Alarm event present
    input wire logic warning_i, // Warning event present
    input wire logic [1:0] adv_do_i, // Advanced diagnostic outputs
    input wire logic [NUM_DO-1:0] dout_i, // Discrete function block outputs
    output logic switch_o // Switch conductive when high
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] on_thr;
        logic [31:0] off_thr;
        logic [15:0] on_dly;
        logic [15:0] off_dly;
        logic cmp;
        logic sw;
        logic ack;
        logic [31:0] rdata;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;
    logic tick;
    logic limit_level;
    func_t func;
    diag_class_t diag_cls;
    fail_mode_t fail_mode;
    logic [3:0] dsrc;
    logic [3:0] lsel;
    logic signed [31:0] meas;
    logic signed [31:0] on_thr;
    logic signed [31:0] off_thr;
    logic event_hit;
    logic dout_val;
    logic raw;
    logic wr;
    logic rd;

    // ------------------------------------------------------------------
    // Time base and delay stage
    // ------------------------------------------------------------------
    swout_tick #(
        .PERIOD(TICK_CYCLES)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    swout_delay #(
        .DW(16)
    ) u_delay (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .target_i(s.cmp),
        .on_dly_i(s.on_dly),
        .off_dly_i(s.off_dly),
        .level_o(limit_level)
    );

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    assign func = func_t'(s.ctrl[`SWOUT_FUNC_LSB +: 3]);
    assign diag_cls = diag_class_t'(s.ctrl[`SWOUT_DIAG_LSB +: 2]);
    assign dsrc = s.ctrl[`SWOUT_DSRC_LSB +: 4];
    assign lsel = s.ctrl[`SWOUT_LSEL_LSB +: 4];
    assign fail_mode = fail_mode_t'(s.ctrl[`SWOUT_FAIL_LSB +: 2]);
    assign on_thr = s.on_thr;
    assign off_thr = s.off_thr;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !s.ack;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !s.ack;

    // Limit selection 1..NUM_VARS picks a variable; 0 means off
    always_comb begin
        meas = '0;
        for (int i = 0; i < NUM_VARS; i++) begin
            if (lsel == 4'(i + 1)) begin
                meas = meas_i[i*32 +: 32];
            end
        end
    end

    // Source 0 off, 1..2 advanced diagnostics, 3.. discrete blocks
    always_comb begin
        dout_val = 1'b0;
        if (dsrc == 4'h1) begin
            dout_val = adv_do_i[0];
        end else if (dsrc == 4'h2) begin
            dout_val = adv_do_i[1];
        end else begin
            for (int i = 0; i < NUM_DO; i++) begin
                if (dsrc == 4'(i + 3)) begin
                    dout_val = dout_i[i];
                end
            end
        end
    end

    always_comb begin
        case (diag_cls)
            DIAG_ALARM: event_hit = alarm_i;
            DIAG_ALARM_WARN: event_hit = alarm_i || warning_i;
            DIAG_WARN: event_hit = warning_i;
            default: event_hit = alarm_i;
        endcase
    end

    // ------------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------------
    always_comb begin
        case (func)
            FUNC_OFF: raw = 1'b0;
            FUNC_ON: raw = 1'b1;
            FUNC_DIAG: raw = !event_hit;
            FUNC_LIMIT: raw = limit_level;
            FUNC_DOUT: raw = dout_val;
            default: raw = 1'b0;
        endcase
        // Failure state overrides only limit and digital modes
        if (alarm_i && (func == FUNC_LIMIT || func == FUNC_DOUT)) begin
            case (fail_mode)
                FAIL_OPEN: raw = 1'b0;
                FAIL_CLOSED: raw = 1'b1;
                default: raw = raw;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Next state: comparator, registers, bus
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.ack = 1'b0;
        // Comparator holds between thresholds and while unassigned
        if (lsel != 4'h0) begin
            if (on_thr > off_thr) begin
                if (meas > on_thr) begin
                    next_s.cmp = 1'b1;
                end else if (meas < off_thr) begin
                    next_s.cmp = 1'b0;
                end
            end else if (on_thr < off_thr) begin
                if (meas < on_thr) begin
                    next_s.cmp = 1'b1;
                end else if (meas > off_thr) begin
                    next_s.cmp = 1'b0;
                end
            end
        end
        next_s.sw = raw ^ s.ctrl[`SWOUT_INV_BIT];
        if (wr) begin
            next_s.ack = 1'b1;
            if (wb_adr_i == `SWOUT_CTRL_ADDR) begin
                for (int b = 0; b < 4; b++) begin
                    if (wb_sel_i[b]) begin
                        next_s.ctrl[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                    end
                end
                next_s.ctrl[31:21] = '0;
            end else if (wb_adr_i == `SWOUT_ON_THR_ADDR) begin
                for (int b = 0; b < 4; b++) begin
                    if (wb_sel_i[b]) begin
                        next_s.on_thr[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                    end
                end
            end else if (wb_adr_i == `SWOUT_OFF_THR_ADDR) begin
                for (int b = 0; b < 4; b++) begin
                    if (wb_sel_i[b]) begin
                        next_s.off_thr[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                    end
                end
            end else if (wb_adr_i == `SWOUT_ON_DLY_ADDR) begin
                // Whole-word write; values above 100.0 s saturate
                if (wb_dat_i[15:0] > `SWOUT_DLY_MAX) begin
                    next_s.on_dly = `SWOUT_DLY_MAX;
                end else begin
                    next_s.on_dly = wb_dat_i[15:0];
                end
            end else if (wb_adr_i == `SWOUT_OFF_DLY_ADDR) begin
                if (wb_dat_i[15:0] > `SWOUT_DLY_MAX) begin
                    next_s.off_dly = `SWOUT_DLY_MAX;
                end else begin
                    next_s.off_dly = wb_dat_i[15:0];
                end
            end
        end
        if (rd) begin
            next_s.ack = 1'b1;
            if (wb_adr_i == `SWOUT_CTRL_ADDR) begin
                next_s.rdata = s.ctrl;
            end else if (wb_adr_i == `SWOUT_ON_THR_ADDR) begin
                next_s.rdata = s.on_thr;
            end else if (wb_adr_i == `SWOUT_OFF_THR_ADDR) begin
                next_s.rdata = s.off_thr;
            end else if (wb_adr_i == `SWOUT_ON_DLY_ADDR) begin
                next_s.rdata = {16'h0000, s.on_dly};
            end else if (wb_adr_i == `SWOUT_OFF_DLY_ADDR) begin
                next_s.rdata = {16'h0000, s.off_dly};
            end else if (wb_adr_i == `SWOUT_STATUS_ADDR) begin
                next_s.rdata = {29'h0, limit_level, s.cmp, s.sw};
            end else begin
                next_s.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s.ctrl <= `SWOUT_CTRL_RST;
            s.on_thr <= `SWOUT_THR_RST;
            s.off_thr <= `SWOUT_THR_RST;
            s.on_dly <= `SWOUT_DLY_RST;
            s.off_dly <= `SWOUT_DLY_RST;
            s.cmp <= 1'b0;
            s.sw <= 1'b0;
            s.ack <= 1'b0;
            s.rdata <= 32'h0000_0000;
        end else begin
            s <= next_s;
        end
    end

    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdata;
    assign switch_o = s.sw;
endmodule // swout_ctrl

//--- bench/load_model.sv
/* Load on the switch output: a relay coil that energises one cycle after
   the switch conducts. Assumes the clock of the controller. */
`timescale 1ns/100ps
module load_model (
    input wire logic clk_i, // Clock
    input wire logic switch_i, // Switch conducts when high
    output logic energized_o // Load energised
);
    always_ff @(posedge clk_i) begin
        energized_o <= switch_i;
    end
endmodule // load_model

//--- bench/swout_checker.sv
/* Port checker of the switch output controller.
   Assumes one clock domain, reset synchronous and active high. */
`timescale 1ns/100ps
module swout_checker (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic [7:0] wb_adr_i, // Address
    input wire logic [3:0] wb_sel_i, // Selects
    input wire logic [31:0] wb_dat_i, // Write data
    input wire logic [31:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Acknowledge
    input wire logic switch_o // Switch state
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req, rd, fix_val, fix_wr;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd = req && !wb_we_i;
    assign fix_val = wb_dat_i[0] ^ wb_dat_i[20];
    // Only fixed modes with full selects, so the result is known here
    assign fix_wr = req && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i == 4'hf
        && wb_dat_i[2:1] == 2'b00;
    chk_ack_timing: assert property (req |=> wb_ack_o)
        else $error("ack late");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_ack_cause: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    chk_reset_open: assert property ($fell(rst_i) |-> !switch_o)
        else $error("switch closed after reset");
    chk_fixed_mode: assert property (fix_wr |-> ##2 switch_o == $past(fix_val, 2))
        else $error("fixed mode wrong");
    chk_unmapped_zero: assert property (rd && wb_adr_i > 8'h14 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_ctrl_top: assert property (rd && wb_adr_i == 8'h00 |=> wb_dat_o[31:21] == 11'h0)
        else $error("control top bits set");
    chk_status_now: assert property (rd && wb_adr_i == 8'h14 |=>
        wb_dat_o[0] == $past(switch_o) && wb_dat_o[31:3] == 29'h0)
        else $error("status wrong");
    cov_fixed: cover property (fix_wr ##2 switch_o);
    cov_status: cover property (rd && wb_adr_i == 8'h14 ##1 wb_dat_o[0]);
    cov_switch: cover property ($rose(switch_o));
endmodule // swout_checker

bind swout_ctrl swout_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .switch_o(switch_o));

//--- bench/tb_top.sv
/* Bench of the switch output controller: Wishbone tasks, mode tests.
   Assumes a short tick of 10 cycles so delays fit the run. */
`timescale 1ns/100ps
module tb_top;
    logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, alarm, warn, sw, load;
    logic [7:0] wb_adr, dout;
    logic [31:0] wb_wdat, wb_rdat, q;
    logic [1:0] adv;
    logic [191:0] meas;
    int n_errors, checked, cycles, i, e;
    swout_ctrl #(.TICK_CYCLES(10)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .meas_i(meas),
        .alarm_i(alarm), .warning_i(warn), .adv_do_i(adv), .dout_i(dout), .switch_o(sw));
    load_model load_u (.clk_i(clk_i), .switch_i(sw), .energized_o(load));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        check("ack", 32'h1, {31'h0, wb_ack});
    endtask
    // Switch settles within three cycles, the load one later
    task automatic hold(input logic [31:0] m, input int w, input logic x);
        meas[31:0] <= m;
        repeat (w + 5) @(posedge clk_i);
        check("switch", {31'h0, x}, {31'h0, sw});
        check("load", {31'h0, x}, {31'h0, load});
    endtask
    task automatic mode(input logic [31:0] c, input logic x);
        xfer(1'b1, 8'h00, c);
        hold(meas[31:0], 0, x);
    endtask
    task automatic end_of_test;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Run needs about 500 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, meas, alarm, warn} = '0;
        rst_i = 1'b1;
        adv = 2'b10;
        dout = 8'ha5;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        xfer(1'b0, 8'h00, 32'h0);
        check("ctrl", 32'h0001_0000, q & 32'h0013_0f37);
        for (i = 4; i <= 24; i += 4) begin
            xfer(1'b0, i[7:0], 32'h0);
            check("reg", 32'h0, q);
        end
        $display("reset test done");
        mode(32'h1, 1'b1);
        alarm <= 1'b1;
        hold(32'h0, 0, 1'b1);
        mode(32'h0, 1'b0);
        alarm <= 1'b0;
        mode(32'h0010_0000, 1'b1);
        xfer(1'b0, 8'h14, 32'h0);
        check("status", 32'h1, q & 32'h1);
        mode(32'h0010_0001, 1'b0);
        $display("fixed test done");
        for (i = 0; i < 3; i++) begin
            for (e = 0; e < 4; e++) begin
                alarm <= e[0];
                warn <= e[1];
                mode(32'h2 | (i << 4), !(i == 0 ? e[0] : i == 1 ? e[0] | e[1] : e[1]));
            end
        end
        {alarm, warn} <= 2'b00;
        for (i = 0; i < 11; i++) begin
            mode(32'h0001_0004 | (i << 8), i == 0 ? 1'b0 : i < 3 ? adv[i-1] : dout[i-3]);
        end
        alarm <= 1'b1;
        for (i = 0; i < 3; i++) begin
            mode(32'h0000_0304 | (i << 16), i != 1);
        end
        alarm <= 1'b0;
        $display("event test done");
        xfer(1'b1, 8'h04, 32'h64);
        xfer(1'b1, 8'h08, 32'hffff_ffce);
        mode(32'h0001_1003, 1'b0);
        hold(32'h78, 0, 1'b1);
        hold(32'h0, 0, 1'b1);
        hold(32'hffff_ffc4, 0, 1'b0);
        xfer(1'b1, 8'h04, 32'hffff_ffce);
        xfer(1'b1, 8'h08, 32'h64);
        hold(32'hffff_ffc4, 0, 1'b1);
        hold(32'h0, 0, 1'b1);
        hold(32'h78, 0, 1'b0);
        $display("limit test done");
        xfer(1'b1, 8'h0c, 32'h3);
        xfer(1'b1, 8'h10, 32'h3);
        hold(32'hffff_ffc4, 10, 1'b0);
        hold(32'hffff_ffc4, 35, 1'b1);
        hold(32'h78, 0, 1'b1);
        hold(32'hffff_ffc4, 45, 1'b1);
        hold(32'h78, 10, 1'b1);
        hold(32'h78, 35, 1'b0);
        xfer(1'b1, 8'h0c, 32'h0);
        mode(32'h0001_0003, 1'b0);
        hold(32'hffff_ffc4, 0, 1'b0);
        xfer(1'b1, 8'h1c, 32'hffff_ffff);
        xfer(1'b0, 8'h00, 32'h0);
        check("ctrl", 32'h0001_0003, q);
        $display("delay test done");
        end_of_test();
    end
endmodule // tb_top
